// ===== cfl_flash_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// serial configuration flash, read stream only
// ---------------------------------------------------------------------------
module cfl_flash_model #(
  parameter int IMAGE_BITS = 128
) (
  // flash bus
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [1:0] width,
  output logic [3:0] io
);
  // even words read as a repeat count of one when the image is compressed
  function automatic logic [31:0] img(input int i);
    return (i % 2 == 0) ? 32'h00000001 : {8'ha5, i[7:0], 16'h3c96};
  endfunction
  function automatic logic img_bit(input int p);
    logic [31:0] w;
    w = img(p / 32);
    return w[31 - p % 32];
  endfunction
  // no write path: contents survive any reset of the loader
  int pos = 0;
  int nb;
  logic [3:0] drv;
  logic [3:0] last = 4'h0;
  always_comb begin
    nb = (width == cfl_pkg::WIDTH_X4) ? 4 :
      (width == cfl_pkg::WIDTH_X2) ? 2 : 1;
    drv = 4'h0;
    for (int j = 0; j < nb; j++) drv[nb-1-j] = img_bit(pos + j);
  end
  always @(negedge cs_n) pos = 0;
  always @(posedge sck) if (cs_n === 1'b0) pos = pos + nb;
  always @(posedge cs_n) last = drv;
  // released lines float; show the inverse so stale data cannot match
  assign io = (cs_n === 1'b0) ? drv : ~last;
endmodule

// ===== cfl_loader.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps

// ---------------------------------------------------------------------------
// word fifo
// ---------------------------------------------------------------------------
module cfl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
  logic push, pop;

  assign in_ready = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
  assign out_valid = wp_reg != rp_reg;
  assign out_data = mem_reg[rp_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (flush) begin
      wp_next = '0;
      rp_next = '0;
    end else begin
      if (push) wp_next = wp_reg + 1'b1;
      if (pop) rp_next = rp_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (push && !flush) mem_reg[wp_reg[AW-1:0]] <= in_data;
  end
endmodule

// ---------------------------------------------------------------------------
// load sequencer
// ---------------------------------------------------------------------------
module cfl_loader #(
  parameter int IMAGE_BITS = cfl_pkg::IMAGE_BITS,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board pins
  input wire logic config_source_select,
  input wire logic config_clear_input,
  // test port
  input wire logic tp_clk,
  input wire logic tp_sel,
  input wire logic tp_din,
  output logic tp_ready,
  // flash bus
  output logic fl_sck,
  input wire logic [cfl_pkg::PIN_COUNT-1:0] fl_pin_in,
  output logic [cfl_pkg::PIN_COUNT-1:0] fl_pin_out,
  output logic [cfl_pkg::PIN_COUNT-1:0] fl_pin_oe,
  // user side after configuration
  input wire logic startup_access_sck,
  input wire logic [cfl_pkg::PIN_COUNT-1:0] usr_pin_out,
  input wire logic [cfl_pkg::PIN_COUNT-1:0] usr_pin_oe,
  output logic [cfl_pkg::PIN_COUNT-1:0] usr_pin_in,
  // configuration memory
  output logic cfg_clear,
  output logic cfg_wr_valid,
  input wire logic cfg_wr_ready,
  output logic [31:0] cfg_wr_data,
  output logic done,
  output logic user_enable
);
  localparam int IMAGE_WORDS = IMAGE_BITS / cfl_pkg::WORD_BITS;
  localparam int SW = 9;
  generate
    if (IMAGE_WORDS < 1 || IMAGE_BITS % cfl_pkg::WORD_BITS != 0)
    begin : g_bad
      $error("image length must be a whole number of words");
    end
  endgenerate

  // -------------------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------------------
  logic [SW-1:0] sync1_reg, sync2_reg;
  logic tpclk_prev_reg, tpsel_prev_reg;
  logic [1:0] warm_reg;
  logic src_s, clr_s, tpclk_s, tpsel_s, tpdin_s;
  logic [cfl_pkg::PIN_COUNT-1:0] pin_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tpclk_prev_reg <= 1'b0;
      tpsel_prev_reg <= 1'b0;
      warm_reg <= 2'h0;
    end else begin
      sync1_reg <= {config_source_select, config_clear_input, tp_clk,
                    tp_sel, tp_din, fl_pin_in[3:0]};
      sync2_reg <= sync1_reg;
      tpclk_prev_reg <= tpclk_s;
      tpsel_prev_reg <= tpsel_s;
      warm_reg <= {warm_reg[0], 1'b1};
    end
  end
  assign {src_s, clr_s, tpclk_s, tpsel_s, tpdin_s} = sync2_reg[8:4];
  assign pin_s = {1'b1, sync2_reg[3:0]};

  // -------------------------------------------------------------------------
  // registers and state
  // -------------------------------------------------------------------------
  cfl_pkg::cfl_state_type state_reg, state_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [1:0] div_reg, div_next;
  logic sck_reg, sck_next, ovf_reg, ovf_next;
  logic [31:0] shift_reg, shift_next, word_reg, word_next;
  logic [5:0] bits_reg, bits_next;
  logic wvld_reg, wvld_next;
  logic [31:0] rep_reg, rep_next, words_reg, words_next;
  logic [31:0] out_reg, out_next;
  logic ovld_reg, ovld_next, hcnt_reg, hcnt_next;
  logic [cfl_pkg::PIN_COUNT-1:0] pout_reg, pout_next, poe_reg, poe_next;
  logic fsck_reg, fsck_next;
  logic apb_wr, stall, fl_evt, tp_evt, tp_start, in_ready;
  logic f_valid, f_ready, flushing, emit, comp;
  logic [31:0] f_data;
  logic [2:0] nbits;
  logic [3:0] bits_in;

  assign comp = ctrl_reg[cfl_pkg::CTRL_COMP_BIT];
  assign apb_wr = psel && penable && pwrite;
  assign tp_start = tpsel_s && !tpsel_prev_reg;
  assign stall = wvld_reg && !in_ready;
  assign flushing = state_reg == cfl_pkg::ST_CLEAR;

  // -------------------------------------------------------------------------
  // apb slave: zero wait states, unmapped addresses answer with pslverr
  // -------------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a == cfl_pkg::ADDR_CTRL || a == cfl_pkg::ADDR_STATUS ||
           a == cfl_pkg::ADDR_COUNT;
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      cfl_pkg::ADDR_CTRL: prdata = {29'h0, ctrl_reg};
      cfl_pkg::ADDR_STATUS: begin
        prdata[cfl_pkg::STAT_DONE_BIT] = done;
        prdata[cfl_pkg::STAT_SRC_BIT] = src_s;
        prdata[cfl_pkg::STAT_OVF_BIT] = ovf_reg;
        prdata[cfl_pkg::STAT_STATE_LSB +: 3] = state_reg;
      end
      cfl_pkg::ADDR_COUNT: prdata = words_reg;
      default: prdata = 32'h0;
    endcase
  end

  // -------------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    if (apb_wr && paddr == cfl_pkg::ADDR_CTRL) ctrl_next = pwdata[2:0];
    case (state_reg)
      cfl_pkg::ST_CLEAR: begin
        // synchronisers show reset values for two edges; wait them out
        if (clr_s || !warm_reg[1]) state_next = cfl_pkg::ST_CLEAR;
        else if (tpsel_s) state_next = cfl_pkg::ST_TP;
        else if (src_s) state_next = cfl_pkg::ST_FLASH;
        else state_next = cfl_pkg::ST_IDLE;
      end
      cfl_pkg::ST_FLASH, cfl_pkg::ST_TP: begin
        if (words_next == 32'(IMAGE_WORDS)) state_next = cfl_pkg::ST_DONE;
        else if (state_reg == cfl_pkg::ST_TP && !tpsel_s)
          state_next = cfl_pkg::ST_IDLE;
      end
      cfl_pkg::ST_IDLE, cfl_pkg::ST_DONE: state_next = state_reg;
      default: state_next = cfl_pkg::ST_CLEAR;
    endcase
    if (clr_s) state_next = cfl_pkg::ST_CLEAR;
    else if (tp_start && state_reg != cfl_pkg::ST_CLEAR)
      state_next = cfl_pkg::ST_CLEAR;
  end

  // -------------------------------------------------------------------------
  // bit capture: flash clock divider and test-port edge detector
  // -------------------------------------------------------------------------
  always_comb begin
    div_next = div_reg;
    sck_next = sck_reg;
    fl_evt = 1'b0;
    // the divider freezes while a word waits, so the flash never overruns
    if (state_reg == cfl_pkg::ST_FLASH && !stall) begin
      if (div_reg == 2'(cfl_pkg::SCK_HALF - 1)) begin
        div_next = 2'h0;
        sck_next = !sck_reg;
        fl_evt = !sck_reg;
      end else begin
        div_next = div_reg + 2'h1;
      end
    end else if (state_reg != cfl_pkg::ST_FLASH) begin
      // two extra counts: first rise waits for data through the sync
      div_next = 2'h2;
      sck_next = 1'b0;
    end
    tp_evt = state_reg == cfl_pkg::ST_TP && tpclk_s && !tpclk_prev_reg;
    case (ctrl_reg[cfl_pkg::CTRL_WIDTH_LSB +: 2])
      cfl_pkg::WIDTH_X2: nbits = 3'h2;
      cfl_pkg::WIDTH_X4: nbits = 3'h4;
      default: nbits = 3'h1;
    endcase
    bits_in = pin_s[3:0];
    if (tp_evt) begin
      nbits = 3'h1;
      bits_in = {3'h0, tpdin_s};
    end
  end

  // -------------------------------------------------------------------------
  // word assembly, msb first
  // -------------------------------------------------------------------------
  always_comb begin
    shift_next = shift_reg;
    bits_next = bits_reg;
    word_next = word_reg;
    wvld_next = wvld_reg && !in_ready;
    ovf_next = ovf_reg;
    // a test-port bit arriving while a word is stuck is lost and flagged
    if (tp_evt && stall) begin
      ovf_next = 1'b1;
    end else if (fl_evt || tp_evt) begin
      case (nbits)
        3'h2: shift_next = {shift_reg[29:0], bits_in[1:0]};
        3'h4: shift_next = {shift_reg[27:0], bits_in};
        default: shift_next = {shift_reg[30:0], bits_in[0]};
      endcase
      if (bits_reg + 6'(nbits) >= 6'(cfl_pkg::WORD_BITS)) begin
        bits_next = 6'h0;
        word_next = shift_next;
        wvld_next = 1'b1;
      end else begin
        bits_next = bits_reg + 6'(nbits);
      end
    end
    if (flushing) begin
      bits_next = 6'h0;
      wvld_next = 1'b0;
      ovf_next = 1'b0;
    end
  end

  assign tp_ready = in_ready;

  cfl_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flushing),
    .in_valid(wvld_reg),
    .in_ready(in_ready),
    .in_data(word_reg),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // -------------------------------------------------------------------------
  // expansion: compressed stream is pairs of repeat count then data word
  // -------------------------------------------------------------------------
  assign emit = ovld_reg && cfg_wr_ready;
  assign f_ready = !flushing && state_reg != cfl_pkg::ST_DONE &&
                   (!ovld_reg || (emit && rep_reg == 32'h0));
  always_comb begin
    out_next = out_reg;
    ovld_next = ovld_reg;
    rep_next = rep_reg;
    hcnt_next = hcnt_reg;
    words_next = words_reg;
    if (emit) begin
      words_next = words_reg + 32'h1;
      if (rep_reg != 32'h0) rep_next = rep_reg - 32'h1;
      else ovld_next = 1'b0;
    end
    if (f_valid && f_ready) begin
      if (comp && !hcnt_reg) begin
        rep_next = f_data;
        hcnt_next = 1'b1;
      end else begin
        out_next = f_data;
        ovld_next = 1'b1;
        rep_next = comp ? rep_reg : 32'h0;
        hcnt_next = 1'b0;
      end
    end
    // image complete: surplus words are dropped, never written
    if (words_next == 32'(IMAGE_WORDS)) ovld_next = 1'b0;
    if (flushing) begin
      ovld_next = 1'b0;
      rep_next = 32'h0;
      hcnt_next = 1'b0;
      words_next = 32'h0;
    end
  end

  // -------------------------------------------------------------------------
  // flash pins: loader drives only chip select and the clock until done, then user logic takes over
  // -------------------------------------------------------------------------
  always_comb begin
    if (state_reg == cfl_pkg::ST_DONE) begin
      pout_next = usr_pin_out;
      poe_next = usr_pin_oe;
      fsck_next = startup_access_sck;
    end else begin
      pout_next = '0;
      poe_next = '0;
      pout_next[cfl_pkg::PIN_CS] = state_reg != cfl_pkg::ST_FLASH;
      poe_next[cfl_pkg::PIN_CS] = 1'b1;
      fsck_next = sck_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cfl_pkg::ST_CLEAR;
      ctrl_reg <= cfl_pkg::CTRL_RESET;
      div_reg <= 2'h0;
      sck_reg <= 1'b0;
      ovf_reg <= 1'b0;
      shift_reg <= 32'h0;
      bits_reg <= 6'h0;
      word_reg <= 32'h0;
      wvld_reg <= 1'b0;
      rep_reg <= 32'h0;
      words_reg <= 32'h0;
      out_reg <= 32'h0;
      ovld_reg <= 1'b0;
      hcnt_reg <= 1'b0;
      pout_reg <= '0;
      poe_reg <= '0;
      fsck_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      ovf_reg <= ovf_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      word_reg <= word_next;
      wvld_reg <= wvld_next;
      rep_reg <= rep_next;
      words_reg <= words_next;
      out_reg <= out_next;
      ovld_reg <= ovld_next;
      hcnt_reg <= hcnt_next;
      pout_reg <= pout_next;
      poe_reg <= poe_next;
      fsck_reg <= fsck_next;
    end
  end

  assign fl_sck = fsck_reg;
  assign fl_pin_out = pout_reg;
  assign fl_pin_oe = poe_reg;
  assign usr_pin_in = state_reg == cfl_pkg::ST_DONE ? pin_s : '0;
  assign cfg_clear = flushing;
  assign cfg_wr_valid = ovld_reg;
  assign cfg_wr_data = out_reg;
  assign done = state_reg == cfl_pkg::ST_DONE;
  assign user_enable = done;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_quiet_clear;
    state_reg == cfl_pkg::ST_CLEAR && warm_reg[1] && !clr_s && !tpsel_s;
  endsequence

  chk_user_gated: assert property (
    $rose(user_enable) |-> words_reg == 32'(IMAGE_WORDS))
    else $error("user logic enabled before full image");
  chk_flash_start: assert property (
    s_quiet_clear ##0 src_s |=> state_reg == cfl_pkg::ST_FLASH)
    else $error("no flash reload after clear");
  chk_flash_off: assert property (
    s_quiet_clear ##0 !src_s |=> state_reg == cfl_pkg::ST_IDLE)
    else $error("flash load started while deselected");
  chk_clear_wipe: assert property (
    clr_s |=> cfg_clear && !done ##1 words_reg == 32'h0)
    else $error("clear did not wipe configuration");
  chk_tp_replace: assert property (
    done && tp_start && !clr_s |=> cfg_clear ##1 !done)
    else $error("test-port image did not replace configuration");
  chk_sck_high: assert property (
    $rose(sck_reg) && state_reg == cfl_pkg::ST_FLASH |-> sck_reg [*2])
    else $error("flash clock high phase too short");
  chk_sck_low: assert property (
    $fell(sck_reg) && state_reg == cfl_pkg::ST_FLASH |-> !sck_reg [*2])
    else $error("flash clock low phase too short");
  chk_pin_release: assert property (
    done |=> fl_pin_out == $past(usr_pin_out) &&
             fl_sck == $past(startup_access_sck))
    else $error("flash pins not released after configuration");
  chk_cs_load: assert property (
    state_reg == cfl_pkg::ST_FLASH ##1 state_reg == cfl_pkg::ST_FLASH
    |-> !fl_pin_out[cfl_pkg::PIN_CS] && fl_pin_oe[cfl_pkg::PIN_CS])
    else $error("chip select not driven during flash load");
  chk_repeat_hold: assert property (
    emit && rep_reg != 32'h0 && !flushing &&
    words_next != 32'(IMAGE_WORDS)
    |=> cfg_wr_valid && $stable(cfg_wr_data))
    else $error("repeated word not held");
  chk_done_level: assert property (
    state_reg == cfl_pkg::ST_TP || state_reg == cfl_pkg::ST_FLASH
    |-> !done)
    else $error("done high during load");
endmodule

// ===== cfl_loader_tb.sv
`timescale 1ns/100ps
module cfl_loader_tb;
  localparam int IMG = 128;
  localparam int NW = IMG / 32;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, wr_data, rd;
  logic src, clr, tp_clk, tp_sel, tp_din, tp_ready, fl_sck, st_sck;
  logic [4:0] pin_in, pin_out, pin_oe, usr_out, usr_oe, usr_in;
  logic cfg_clear, wr_valid, wr_ready, done, user_enable, err, ovf_seen;
  logic [3:0] fl_io;
  logic [1:0] fl_width;
  logic [31:0] got[$];
  logic [31:0] exp_q[NW];
  int mismatches = 0;
  int n_checks = 0;
  realtime t_last = 0;
  realtime min_per = 1e9;

  // ---------------------------------------------------------------------------
  // design, flash and pin wiring
  // ---------------------------------------------------------------------------
  cfl_loader #(.IMAGE_BITS(IMG), .FIFO_DEPTH(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_source_select(src),
    .config_clear_input(clr), .tp_clk(tp_clk), .tp_sel(tp_sel),
    .tp_din(tp_din), .tp_ready(tp_ready), .fl_sck(fl_sck),
    .fl_pin_in(pin_in), .fl_pin_out(pin_out), .fl_pin_oe(pin_oe),
    .startup_access_sck(st_sck), .usr_pin_out(usr_out),
    .usr_pin_oe(usr_oe), .usr_pin_in(usr_in), .cfg_clear(cfg_clear),
    .cfg_wr_valid(wr_valid), .cfg_wr_ready(wr_ready),
    .cfg_wr_data(wr_data), .done(done), .user_enable(user_enable));
  cfl_flash_model #(.IMAGE_BITS(IMG)) u_flash (
    .sck(fl_sck), .cs_n(pin_in[4]), .width(fl_width), .io(fl_io));
  // chip select has a pull-up; data lines come from the flash when free
  always_comb begin
    pin_in[4] = pin_oe[4] ? pin_out[4] : 1'b1;
    for (int i = 0; i < 4; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : fl_io[i];
  end
  always @(posedge pclk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_data);
  end
  always @(posedge fl_sck) begin
    if (pin_in[4] === 1'b0 && done !== 1'b1) begin
      if ($realtime - t_last < min_per) min_per = $realtime - t_last;
      t_last = $realtime;
    end
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chkb(err, ee);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 8000; i++) begin
      if (done === 1'b1) break;
      @(posedge pclk);
    end
    chkb(done, 1'b1);
  endtask
  task automatic chk_words();
    chk(32'(got.size()), NW);
    for (int i = 0; i < NW && i < got.size(); i++) chk(got[i], exp_q[i]);
  endtask
  task automatic tp_load(input int n, input logic [31:0] base);
    got.delete();
    tp_sel <= 1'b1;
    cyc(6);
    chkb(done, 1'b0);
    for (int k = 0; k < n; k++) begin
      if (k < NW) exp_q[k] = base + k;
      for (int b = 31; b >= 0; b--) begin
        tp_din <= base[b] ^ k[b];
        tp_clk <= 1'b0;
        cyc(8);
        tp_clk <= 1'b1;
        if (tp_ready === 1'b0) ovf_seen = 1'b1;
        cyc(8);
      end
      if (k < NW) exp_q[k] = base ^ k;
    end
    tp_din <= ~tp_din;
    tp_clk <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_idle();
    cyc(40);
    chkb(done, 1'b0);
    chkb(user_enable, 1'b0);
    chk(32'(pin_oe), 32'h10);
    chkb(pin_out[4], 1'b1);
    rd_chk(cfl_pkg::ADDR_CTRL, 32'h0, 1'b0);
    rd_chk(cfl_pkg::ADDR_STATUS, 32'h0, 1'b0);
    rd_chk(cfl_pkg::ADDR_COUNT, 32'h0, 1'b0);
    apb(1'b1, 8'h0c, 32'hffffffff);
    rd_chk(8'h0c, 32'h0, 1'b1);
    $display("idle test ended");
  endtask
  task automatic t_powerup();
    src <= 1'b1;
    presetn <= 1'b0;
    cyc(16);
    got.delete();
    fl_width = cfl_pkg::WIDTH_X1;
    for (int i = 0; i < NW; i++) exp_q[i] = u_flash.img(i);
    presetn <= 1'b1;
    cyc(20);
    chk(32'(pin_oe), 32'h10);
    chkb(pin_out[4], 1'b0);
    chkb(user_enable, 1'b0);
    wait_done();
    chk_words();
    rd_chk(cfl_pkg::ADDR_STATUS, 32'h33, 1'b0);
    rd_chk(cfl_pkg::ADDR_COUNT, NW, 1'b0);
    $display("power-up flash test ended");
  endtask
  task automatic t_modes();
    logic [2:0] m[4] = '{3'h1, 3'h2, 3'h6, 3'h4};
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, cfl_pkg::ADDR_CTRL, {29'h0, m[t]});
      rd_chk(cfl_pkg::ADDR_CTRL, {29'h0, m[t]}, 1'b0);
      fl_width = m[t][1:0];
      for (int i = 0; i < NW; i++)
        exp_q[i] = u_flash.img(m[t][2] ? (i / 2) * 2 + 1 : i);
      clr <= 1'b1;
      cyc(6);
      chkb(cfg_clear, 1'b1);
      chkb(done, 1'b0);
      rd_chk(cfl_pkg::ADDR_STATUS, 32'h42, 1'b0);
      clr <= 1'b0;
      cyc(40);
      chkb(done, 1'b0);
      chkb(pin_in[4], 1'b0);
      clr <= 1'b1;
      cyc(4);
      chkb(cfg_clear, 1'b1);
      got.delete();
      wr_ready <= 1'b0;
      clr <= 1'b0;
      cyc(300);
      wr_ready <= 1'b1;
      wait_done();
      chk_words();
      rd_chk(cfl_pkg::ADDR_COUNT, NW, 1'b0);
    end
    chkb(min_per >= 20.0, 1'b1);
    $display("flash width and compression test ended");
  endtask
  task automatic t_hold_user();
    apb(1'b1, cfl_pkg::ADDR_CTRL, 32'h0);
    src <= 1'b0;
    cyc(500);
    chkb(done, 1'b1);
    rd_chk(cfl_pkg::ADDR_COUNT, NW, 1'b0);
    usr_out <= 5'h1a;
    usr_oe <= 5'h1f;
    st_sck <= 1'b1;
    cyc(6);
    chk(32'(pin_oe), 32'h1f);
    chk(32'(pin_out), 32'h1a);
    chk(32'(usr_in), 32'h1a);
    chkb(fl_sck, 1'b1);
    st_sck <= 1'b0;
    cyc(6);
    chkb(fl_sck, 1'b0);
    usr_oe <= 5'h00;
    $display("hold and user pin test ended");
  endtask
  task automatic t_tp();
    tp_load(NW, 32'h6d2b0010);
    wait_done();
    chk_words();
    tp_sel <= 1'b0;
    rd_chk(cfl_pkg::ADDR_COUNT, NW, 1'b0);
    $display("test port test ended");
  endtask
  task automatic t_tp_ovf();
    src <= 1'b1;
    wr_ready <= 1'b0;
    ovf_seen = 1'b0;
    tp_load(8, 32'h1e48c700);
    chkb(ovf_seen, 1'b1);
    rd_chk(cfl_pkg::ADDR_STATUS, 32'h26, 1'b0);
    wr_ready <= 1'b1;
    wait_done();
    chk_words();
    rd_chk(cfl_pkg::ADDR_STATUS, 32'h37, 1'b0);
    tp_sel <= 1'b0;
    $display("test port overflow test ended");
  endtask

  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, src, clr, tp_clk, tp_sel} = 8'h0;
    {tp_din, st_sck, wr_ready} = 3'b001;
    paddr = 8'h0;
    pwdata = 32'h0;
    usr_out = 5'h0;
    usr_oe = 5'h0;
    fl_width = cfl_pkg::WIDTH_X1;
    cyc(16);
    presetn <= 1'b1;
    t_idle();
    t_powerup();
    t_modes();
    t_hold_user();
    t_tp();
    t_tp_ovf();
    summarize();
  end
endmodule

// ===== cfl_pkg.sv
// ---------------------------------------------------------------------------
// constants for the configuration load sequencer
// ---------------------------------------------------------------------------
package cfl_pkg;

  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;

  // control register fields
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_COMP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // flash data width codes
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X2 = 2'h1;
  localparam logic [1:0] WIDTH_X4 = 2'h2;

  // status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_SRC_BIT = 1;
  localparam int STAT_OVF_BIT = 2;
  localparam int STAT_STATE_LSB = 4;

  // timing
  localparam int CLK_MHZ = 200;
  localparam int SCK_MAX_MHZ = 50;
  localparam int SCK_HALF =
    (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);

  // image size
  localparam int IMAGE_BITS = 17536096;
  localparam int WORD_BITS = 32;

  // pin vector layout: bits 3:0 data lines, bit 4 chip select
  localparam int PIN_CS = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'h4,
    ST_IDLE = 3'h0,
    ST_FLASH = 3'h1,
    ST_DONE = 3'h3,
    ST_TP = 3'h2
  } cfl_state_type;

endpackage
